/* design/hfp_fifo.sv */
/*
 * Shift-register queue: head is always entry 0, flags are registered.
 * Assumes push and pop are single-cycle requests taken while ce is high.
 */
module hfp_fifo import hfp_pkg::*; (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          ce,
	input  wire logic          flush,
	input  wire logic [CW-1:0] limit,
	input  wire logic          push,
	input  wire logic [DW-1:0] din,
	input  wire logic          pop,
	output logic      [DW-1:0] head,
	output logic               full,
	output logic               empty,
	output logic      [CW-1:0] count
);
	logic [DW-1:0] mem_q [DEPTH];
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          do_push;
	logic          do_pop;

	assign do_pop  = pop && !empty;
	assign do_push = push && !full;
	assign cnt_d   = cnt_q + CW'(do_push) - CW'(do_pop);
	assign head    = mem_q[0];
	assign count   = cnt_q;

	// ==========================================================
	// Occupancy and flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			full  <= 1'b0;
			empty <= 1'b1;
		end else if (ce) begin
			if (flush) begin
				cnt_q <= '0;
				full  <= (limit == '0);
				empty <= 1'b1;
			end else begin
				cnt_q <= cnt_d;
				// Limit caps capacity at or below the physical depth
				full  <= (cnt_d >= limit) || (cnt_d == CW'(DEPTH));
				empty <= (cnt_d == '0);
			end
		end
	end

	// ==========================================================
	// Storage
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		localparam int NX = (i == DEPTH - 1) ? i : i + 1;
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				mem_q[i] <= '0;
			end else if (ce && !flush) begin
				if (do_push && (CW'(i) == cnt_q - CW'(do_pop))) begin
					mem_q[i] <= din;
				end else if (do_pop) begin
					mem_q[i] <= mem_q[NX];
				end
			end
		end
	end
endmodule

/* design/hfp_pkg.sv */
/*
 * Shared constants and types for the host FIFO port access block.
 * Assumes one 10 MHz clock and a host that moves 32-bit words as two 16-bit halves.
 */
package hfp_pkg;
	// ==========================================================
	// Widths and depths
	localparam int DW    = 32;
	localparam int HW    = 16;
	localparam int AW    = 8;
	localparam int DEPTH = 8;
	localparam int CW    = 4;
	localparam int NQ    = 4;
	localparam int NEV   = 4;
	localparam int KW    = 8;

	// ==========================================================
	// Queue indices
	localparam int Q_RXS = 0;
	localparam int Q_RXD = 1;
	localparam int Q_TXS = 2;
	localparam int Q_TXD = 3;

	// ==========================================================
	// Host address map, byte offsets
	localparam logic [AW-1:0] OFF_RXD      = 8'h00;
	localparam logic [AW-1:0] OFF_TXD      = 8'h40;
	localparam logic [AW-1:0] ALIAS_MASK   = 8'hC0;
	localparam logic [AW-1:0] OFF_RXS_POP  = 8'h80;
	localparam logic [AW-1:0] OFF_RXS_PEEK = 8'h84;
	localparam logic [AW-1:0] OFF_TXS_POP  = 8'h88;
	localparam logic [AW-1:0] OFF_TXS_PEEK = 8'h8C;
	localparam logic [AW-1:0] OFF_EVT      = 8'h90;
	localparam logic [AW-1:0] OFF_CTL      = 8'h94;
	localparam logic [AW-1:0] OFF_CFG      = 8'h98;
	localparam logic [AW-1:0] OFF_WO       = 8'h9C;
	localparam logic [AW-1:0] OFF_ID       = 8'hA0;
	localparam int            HALF_BIT     = 1;

	// ==========================================================
	// Field positions
	localparam int EVT_W1C_LSB  = 0;
	localparam int EVT_RC_LSB   = 4;
	localparam int EVT_LH_BIT   = 8;
	localparam int EVT_LL_BIT   = 9;
	localparam int CTL_SRST_BIT = 0;
	localparam int CTL_KEEP_LSB = 8;
	localparam int CFG_RXD_LSB  = 0;
	localparam int CFG_TXD_LSB  = 8;
	localparam int CFG_RXS_LSB  = 16;

	// ==========================================================
	// Reset values
	localparam logic [DW-1:0] CFG_MASK = 32'h000F_0F0F;
	localparam logic [DW-1:0] CFG_RST  = 32'h0008_0808;
	localparam logic [DW-1:0] WO_RST   = 32'h0000_0000;
	localparam logic [KW-1:0] KEEP_RST = 8'h00;
	localparam logic [CW-1:0] FULL_LIM = 4'h8;
	// Arbitrary identity value
	localparam logic [DW-1:0] ID_VALUE = 32'h0000_A5A5;

	typedef enum logic [3:0] {
		R_NONE, R_RXD, R_TXD, R_RXS_POP, R_RXS_PEEK, R_TXS_POP,
		R_TXS_PEEK, R_EVT, R_CTL, R_CFG, R_WO, R_ID
	} hfp_region_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic          rd;
		logic          wr;
		logic [HW-1:0] wdata;
	} hfp_host_req_t;

	typedef struct packed {
		logic          push;
		logic [DW-1:0] data;
	} hfp_push_t;
endpackage

/* design/hfp_top.sv */
/*
 * Host access port: queue pop, peek and alias windows plus attribute registers.
 * Assumes a host that issues low half then high half of each 32-bit word.
 */
// Functional notes
// - Writes to read-only fields change nothing
// - Write-only locations read back as zero
// - Writing one clears bit, zero ignored
// - Read returns value then clears bits
// - Latched bits hold until register read
// - Kept field survives software reset
// - Every reset loads register defaults, except the kept field on software reset
// - Four queues, three sizes configurable
// - Receive queues read-only, separate locations
// - Receive status pop read removes head
// - Receive status peek leaves queue intact
// - Receive data read advances queue
// - Receive data at sixteen aliased words
// - Transmit status pop read removes head
// - Transmit status peek leaves queue intact
// - Transmit data writes through sixteen aliases
// - Two 16-bit halves form one word
module hfp_top import hfp_pkg::*; (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic           ce,
	input  wire hfp_host_req_t  host_req,
	output logic      [HW-1:0]  host_rdata,
	output logic                host_rvalid,
	input  wire hfp_push_t      rxs_in,
	input  wire hfp_push_t      rxd_in,
	input  wire hfp_push_t      txs_in,
	output logic                rxs_full,
	output logic                rxd_full,
	output logic                txs_full,
	input  wire logic           txd_pop,
	output logic      [DW-1:0]  txd_head,
	output logic                txd_empty,
	input  wire logic [NEV-1:0] ev_w1c,
	input  wire logic [NEV-1:0] ev_rc,
	input  wire logic           link_up,
	output logic      [DW-1:0]  tx_cmd
);
	hfp_region_t    rg;
	logic           hi;
	logic           rd_lo;
	logic           rd_hi;
	logic           wr_lo;
	logic           wr_hi;
	logic           evt_rd;
	logic [DW-1:0]  wword;
	logic [DW-1:0]  rword;
	logic [DW-1:0]  hold_q;
	logic [HW-1:0]  wlo_q;
	logic [NEV-1:0] w1c_q;
	logic [NEV-1:0] rc_q;
	logic           lh_q;
	logic           ll_q;
	logic           soft_q;
	logic [KW-1:0]  keep_q;
	logic [DW-1:0]  cfg_q;
	logic [DW-1:0]  wo_q;
	logic [NQ-1:0]  q_push;
	logic [NQ-1:0]  q_pop;
	logic [NQ-1:0]  q_full;
	logic [NQ-1:0]  q_empty;
	logic [DW-1:0]  q_din  [NQ];
	logic [DW-1:0]  q_head [NQ];
	logic [CW-1:0]  q_lim  [NQ];
	logic [CW-1:0]  q_cnt  [NQ];

	// ==========================================================
	// Address decode
	function automatic hfp_region_t region_of(input logic [AW-1:0] a);
		logic [AW-1:0] dw;
		dw = {a[AW-1:2], 2'b00};
		if ((dw & ALIAS_MASK) == OFF_RXD) begin
			return R_RXD;
		end else if ((dw & ALIAS_MASK) == OFF_TXD) begin
			return R_TXD;
		end
		case (dw)
			OFF_RXS_POP:  return R_RXS_POP;
			OFF_RXS_PEEK: return R_RXS_PEEK;
			OFF_TXS_POP:  return R_TXS_POP;
			OFF_TXS_PEEK: return R_TXS_PEEK;
			OFF_EVT:      return R_EVT;
			OFF_CTL:      return R_CTL;
			OFF_CFG:      return R_CFG;
			OFF_WO:       return R_WO;
			OFF_ID:       return R_ID;
			default:      return R_NONE;
		endcase
	endfunction

	assign rg     = region_of(host_req.addr);
	assign hi     = host_req.addr[HALF_BIT];
	assign rd_lo  = ce && host_req.rd && !hi;
	assign rd_hi  = ce && host_req.rd && hi;
	assign wr_lo  = ce && host_req.wr && !hi;
	assign wr_hi  = ce && host_req.wr && hi;
	assign wword  = {host_req.wdata, wlo_q};
	// register read taken at low half
	assign evt_rd = rd_lo && (rg == R_EVT);

	// ==========================================================
	// Read word assembly
	always_comb begin
		rword = '0;
		case (rg)
			R_RXD: rword = q_head[Q_RXD];
			// peek shares the pop data path
			R_RXS_POP, R_RXS_PEEK: rword = q_head[Q_RXS];
			// peek shares the pop data path
			R_TXS_POP, R_TXS_PEEK: rword = q_head[Q_TXS];
			R_EVT: begin
				rword[EVT_W1C_LSB +: NEV] = w1c_q;
				rword[EVT_RC_LSB +: NEV]  = rc_q;
				rword[EVT_LH_BIT]         = lh_q;
				rword[EVT_LL_BIT]         = ll_q;
			end
			R_CTL: begin
				rword[CTL_SRST_BIT]       = soft_q;
				rword[CTL_KEEP_LSB +: KW] = keep_q;
			end
			R_CFG: rword = cfg_q;
			R_ID:  rword = ID_VALUE;
			default: rword = '0;
		endcase
	end

	// ==========================================================
	// Host read path
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_rvalid <= 1'b0;
			host_rdata  <= '0;
			hold_q      <= '0;
		end else if (ce) begin
			host_rvalid <= host_req.rd;
			if (rd_lo) begin
				hold_q     <= rword;
				host_rdata <= rword[HW-1:0];
			end else if (rd_hi) begin
				host_rdata <= hold_q[DW-1:HW];
			end
		end
	end

	// Low half of a write waits for its partner
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wlo_q <= '0;
		end else if (wr_lo) begin
			wlo_q <= host_req.wdata;
		end
	end

	// ==========================================================
	// Event flags; a new event beats a write or read clear, but software reset clears it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			w1c_q <= '0;
		end else if (ce) begin
			if (soft_q) begin
				w1c_q <= '0;
			end else if (wr_hi && (rg == R_EVT)) begin
				w1c_q <= (w1c_q & ~wword[EVT_W1C_LSB +: NEV]) | ev_w1c;
			end else begin
				w1c_q <= w1c_q | ev_w1c;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rc_q <= '0;
		end else if (ce) begin
			if (soft_q) begin
				rc_q <= '0;
			end else begin
				rc_q <= (evt_rd ? '0 : rc_q) | ev_rc;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lh_q <= 1'b0;
			ll_q <= 1'b0;
		end else if (ce) begin
			if (soft_q) begin
				lh_q <= 1'b0;
				ll_q <= 1'b0;
			end else begin
				lh_q <= (lh_q && !evt_rd) || link_up;
				ll_q <= (ll_q && !evt_rd) || !link_up;
			end
		end
	end

	// ==========================================================
	// Control and configuration
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			soft_q <= 1'b0;
		end else if (ce) begin
			// Self-clearing one-cycle software reset
			soft_q <= wr_hi && (rg == R_CTL) && wword[CTL_SRST_BIT] && !soft_q;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			keep_q <= KEEP_RST;
		end else if (wr_hi && (rg == R_CTL)) begin
			keep_q <= wword[CTL_KEEP_LSB +: KW];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= CFG_RST;
			wo_q  <= WO_RST;
		end else if (ce) begin
			if (soft_q) begin
				cfg_q <= CFG_RST;
				wo_q  <= WO_RST;
			end else if (wr_hi) begin
				if (rg == R_CFG) begin
					cfg_q <= wword & CFG_MASK;
				end
				if (rg == R_WO) begin
					wo_q <= wword;
				end
			end
		end
	end

	assign tx_cmd = wo_q;

	// ==========================================================
	// Queues
	// sizes from config, transmit status fixed
	assign q_lim[Q_RXS] = cfg_q[CFG_RXS_LSB +: CW];
	assign q_lim[Q_RXD] = cfg_q[CFG_RXD_LSB +: CW];
	assign q_lim[Q_TXS] = FULL_LIM;
	assign q_lim[Q_TXD] = cfg_q[CFG_TXD_LSB +: CW];

	assign q_push[Q_RXS] = rxs_in.push;
	assign q_push[Q_RXD] = rxd_in.push;
	assign q_push[Q_TXS] = txs_in.push;
	assign q_push[Q_TXD] = wr_hi && (rg == R_TXD);
	assign q_din[Q_RXS]  = rxs_in.data;
	assign q_din[Q_RXD]  = rxd_in.data;
	assign q_din[Q_TXS]  = txs_in.data;
	assign q_din[Q_TXD]  = wword;

	assign q_pop[Q_RXS] = rd_hi && (rg == R_RXS_POP);
	assign q_pop[Q_RXD] = rd_hi && (rg == R_RXD);
	assign q_pop[Q_TXS] = rd_hi && (rg == R_TXS_POP);
	assign q_pop[Q_TXD] = txd_pop;

	for (genvar q = 0; q < NQ; q++) begin : g_q
		hfp_fifo u_fifo (
			.clk   (clk),
			.rstn  (rstn),
			.ce    (ce),
			.flush (soft_q),
			.limit (q_lim[q]),
			.push  (q_push[q]),
			.din   (q_din[q]),
			.pop   (q_pop[q]),
			.head  (q_head[q]),
			.full  (q_full[q]),
			.empty (q_empty[q]),
			.count (q_cnt[q])
		);
	end

	assign rxs_full  = q_full[Q_RXS];
	assign rxd_full  = q_full[Q_RXD];
	assign txs_full  = q_full[Q_TXS];
	assign txd_head  = q_head[Q_TXD];
	assign txd_empty = q_empty[Q_TXD];

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	ro_evt_bits_a: assert property (
		wr_hi && rg == R_EVT && !soft_q && ev_rc == '0 |=> rc_q == $past(rc_q))
		else $error("read-only bits changed by write");
	wo_read_zero_a: assert property (
		rd_lo && (rg == R_WO || rg == R_TXD) |=> host_rdata == '0)
		else $error("write-only location read nonzero");
	w1c_clear_a: assert property (
		wr_hi && rg == R_EVT && !soft_q && wword[EVT_W1C_LSB] && !ev_w1c[0]
		|=> !w1c_q[0])
		else $error("write one did not clear");
	rc_read_a: assert property (
		evt_rd && !soft_q && ev_rc == '0
		|=> rc_q == '0 && host_rdata[EVT_RC_LSB +: NEV] == $past(rc_q))
		else $error("clear on read misbehaved");
	latch_hold_a: assert property (
		ce && lh_q && !evt_rd && !soft_q |=> lh_q)
		else $error("latched bit dropped without read");
	keep_soft_a: assert property (
		soft_q && !(wr_hi && rg == R_CTL) |=> keep_q == $past(keep_q))
		else $error("kept field lost on software reset");
	soft_dflt_a: assert property (
		ce && soft_q |=> cfg_q == CFG_RST && wo_q == WO_RST && q_cnt[Q_RXD] == '0)
		else $error("software reset left non-default state");
	rxs_pop_a: assert property (
		q_pop[Q_RXS] && !q_empty[Q_RXS] && !rxs_in.push && !soft_q
		|=> q_cnt[Q_RXS] == $past(q_cnt[Q_RXS]) - 4'h1)
		else $error("receive status pop lost");
	rxs_peek_a: assert property (
		rd_hi && rg == R_RXS_PEEK && !rxs_in.push && !soft_q
		|=> $stable(q_cnt[Q_RXS]))
		else $error("peek changed occupancy");
	half_nopop_a: assert property (
		rd_lo && rg == R_RXD && !rxd_in.push && !soft_q |=> $stable(q_cnt[Q_RXD]))
		else $error("queue advanced on low half");
	txd_push_a: assert property (
		q_push[Q_TXD] && !q_full[Q_TXD] && !txd_pop && !soft_q
		|=> q_cnt[Q_TXD] == $past(q_cnt[Q_TXD]) + 4'h1)
		else $error("transmit data push lost");
	rxq_wr_a: assert property (
		wr_hi && rg == R_RXS_POP && !rxs_in.push && !soft_q |=> $stable(q_cnt[Q_RXS]))
		else $error("write altered receive status queue");

	rxs_pop_c:  cover property (q_pop[Q_RXS] && !q_empty[Q_RXS]);
	txd_full_c: cover property (q_push[Q_TXD] && q_full[Q_TXD]);
	soft_rst_c: cover property (soft_q);
	evt_read_c: cover property (evt_rd && rc_q != '0);
endmodule

/* verification/hfp_host_model.sv */
/*
 * Host CPU model on the 16-bit bus: builds each 32-bit word from two halves.
 * Assumes the block samples on the rising edge; the model drives at the falling edge.
 */
module hfp_host_model import hfp_pkg::*; (
	input  wire logic          clk,
	output hfp_host_req_t      host_req,
	input  wire logic [HW-1:0] host_rdata,
	input  wire logic          host_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;

	initial host_req = '{addr: 8'hFF, rd: 1'b0, wr: 1'b0, wdata: 16'h0000};

	// ==========================================================
	// Word transfer
	// halves in order
	task automatic xfer(input logic [AW-1:0] a, input logic w, input logic [DW-1:0] d,
			output logic [DW-1:0] q);
		@(negedge clk);
		host_req.addr = a & 8'hFC;
		host_req.rd = !w;
		host_req.wr = w;
		host_req.wdata = d[15:0];
		@(negedge clk);
		// A missing read answer spoils the word, so the bench sees it
		q[15:0] = host_rvalid ? host_rdata : ~host_rdata;
		host_req.addr = a | 8'h02;
		host_req.wdata = d[31:16];
		@(negedge clk);
		q[31:16] = host_rvalid ? host_rdata : ~host_rdata;
		host_req.rd = 1'b0;
		host_req.wr = 1'b0;
		// Released lines toggle so stale data never looks valid
		host_req.addr = ~host_req.addr;
		host_req.wdata = ~host_req.wdata;
	endtask
endmodule

/* verification/test_host_fifo_port_access.sv */
/*
 * Self-checking bench for the host FIFO port access block.
 * Assumes the host model instance drives every host bus transfer.
 */
module test_host_fifo_port_access import hfp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic           clk = 1'b0;
	logic           rstn = 1'b0;
	logic           ce = 1'b1;
	hfp_host_req_t  host_req;
	logic [HW-1:0]  host_rdata;
	logic           host_rvalid;
	hfp_push_t      pin [3] = '{default: '0};
	logic           rxs_full, rxd_full, txs_full;
	logic           txd_pop = 1'b0;
	logic [DW-1:0]  txd_head;
	logic           txd_empty;
	logic [NEV-1:0] ev_w1c = 4'h0;
	logic [NEV-1:0] ev_rc = 4'h0;
	logic           link_up = 1'b0;
	logic [DW-1:0]  tx_cmd;
	int             bad_count = 0;
	int             comparisons = 0;
	int             cycles = 0;
	logic [DW-1:0]  q;

	always #50 clk = ~clk;

	hfp_top DUT (.clk(clk), .rstn(rstn), .ce(ce), .host_req(host_req),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid), .rxs_in(pin[Q_RXS]),
		.rxd_in(pin[Q_RXD]), .txs_in(pin[Q_TXS]), .rxs_full(rxs_full),
		.rxd_full(rxd_full), .txs_full(txs_full), .txd_pop(txd_pop),
		.txd_head(txd_head), .txd_empty(txd_empty), .ev_w1c(ev_w1c), .ev_rc(ev_rc),
		.link_up(link_up), .tx_cmd(tx_cmd));

	hfp_host_model HOST (.clk(clk), .host_req(host_req), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid));

	// ==========================================================
	// Helpers
	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [AW-1:0] a);
		HOST.xfer(a, 1'b0, 32'h0, q);
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [DW-1:0] junk;
		HOST.xfer(a, 1'b1, d, junk);
	endtask

	task automatic push(input int qi, input logic [DW-1:0] d);
		@(negedge clk);
		pin[qi] = '{push: 1'b1, data: d};
		@(negedge clk);
		pin[qi] = '{push: 1'b0, data: ~d};
	endtask

	task automatic close_out;
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check(txd_empty, 1'b1);
		check({rxs_full, rxd_full, txs_full, host_rvalid}, 4'h0);
		check(tx_cmd, 32'h0);
	endtask

	task automatic t_status(input logic [AW-1:0] pop, input logic [AW-1:0] peek, input int qi);
		push(qi, 32'h1111_0000 + pop);
		push(qi, 32'h2222_0000 + pop);
		wr(pop, 32'hDEAD_BEEF);
		wr(peek, 32'hDEAD_BEEF);
		rd(peek);
		check(q, 32'h1111_0000 + pop);
		rd(peek);
		check(q, 32'h1111_0000 + pop);
		rd(pop);
		check(q, 32'h1111_0000 + pop);
		rd(pop);
		check(q, 32'h2222_0000 + pop);
	endtask

	task automatic t_rxd;
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 8; i++)
				push(Q_RXD, 32'hC000_0000 + r * 8 + i);
			check(rxd_full, 1'b1);
			for (int i = 0; i < 8; i++) begin
				rd(OFF_RXD + 8'((r * 8 + i) * 4));
				check(q, 32'hC000_0000 + r * 8 + i);
			end
			check(rxd_full, 1'b0);
		end
	endtask

	task automatic t_txd;
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 8; i++)
				wr(OFF_TXD + 8'((r * 8 + i) * 4), 32'h7000_0000 + r * 8 + i);
			rd(OFF_TXD + 8'(r * 4));
			check(q, 32'h0);
			for (int i = 0; i < 8; i++) begin
				check(txd_head, 32'h7000_0000 + r * 8 + i);
				@(negedge clk);
				txd_pop = 1'b1;
				@(negedge clk);
				txd_pop = 1'b0;
				@(negedge clk);
			end
			check(txd_empty, 1'b1);
		end
	endtask

	task automatic t_regs;
		wr(OFF_WO, 32'h1234_5678);
		check(tx_cmd, 32'h1234_5678);
		// Frozen clock enable must drop both halves
		ce = 1'b0;
		wr(OFF_WO, 32'h0BAD_F00D);
		ce = 1'b1;
		check(tx_cmd, 32'h1234_5678);
		rd(OFF_WO);
		check(q, 32'h0);
		wr(OFF_ID, ~ID_VALUE);
		rd(OFF_ID);
		check(q, ID_VALUE);
		rd(8'hB0);
		check(q, 32'h0);
	endtask

	task automatic t_events;
		@(negedge clk);
		ev_w1c = 4'h5;
		ev_rc = 4'h2;
		link_up = 1'b1;
		@(negedge clk);
		ev_w1c = 4'h0;
		ev_rc = 4'h0;
		link_up = 1'b0;
		rd(OFF_EVT);
		check(q[9:0], 10'h325);
		wr(OFF_EVT, 32'h0000_0001);
		rd(OFF_EVT);
		// Link still low, so its latch sets again
		check(q[9:0], 10'h204);
	endtask

	task automatic t_soft;
		// Transmit data limit kept nonzero so the push lands
		wr(OFF_CFG, 32'h0002_0804);
		for (int i = 0; i < 8; i++) begin
			push(Q_TXS, 32'hB0 + i);
			if (i < 4)
				push(Q_RXD, 32'hA0 + i);
			if (i < 2)
				push(Q_RXS, 32'hC0 + i);
		end
		check({rxs_full, rxd_full, txs_full}, 3'b111);
		wr(OFF_TXD, 32'h5);
		check(txd_empty, 1'b0);
		wr(OFF_CTL, 32'h0000_5A01);
		repeat (3) @(negedge clk);
		check({txd_empty, rxs_full, rxd_full, txs_full}, 4'h8);
		check(tx_cmd, 32'h0);
		rd(OFF_CFG);
		check(q, CFG_RST);
		rd(OFF_CTL);
		check(q[15:0], 16'h5A00);
		@(negedge clk);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		t_reset;
		rd(OFF_CTL);
		check(q[15:0], 16'h0000);
	endtask

	// ==========================================================
	// Main sequence and hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("unexpected at %0t: run did not finish", $time);
			close_out;
		end
	end

	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		t_reset;
		t_status(OFF_RXS_POP, OFF_RXS_PEEK, Q_RXS);
		t_status(OFF_TXS_POP, OFF_TXS_PEEK, Q_TXS);
		t_rxd;
		t_txd;
		t_regs;
		t_events;
		t_soft;
		close_out;
	end
endmodule
